// ### pkg/synreg_map.vh
// Purpose: Offsets, field positions, reset values and frame counts of the control bank
// Assumes: Included by the serial bank and its serial shifter
// Notes:   Field positions are bit indices within a 24-bit register
// Notes on behaviour
// [RULE1] Core bias bit 1 cleared disables the whole loop.
// [RULE2] Reference divider run bit 2 cleared holds the divider in reset.
// [RULE3] Bit 9 picks divided VCO or divided reference as modulator clock.
// [RULE4] Pump enable bit 12 cleared tri-states the charge pump output.
// [RULE5] Bit 13 low holds the fractional modulator in reset.
// [RULE6] Bit 14 low holds the lock detector in reset.
// [RULE7] Bit 11 enables digital lock logic and detector lock output gates.
// [RULE8] Bit 15 set enables slip guard; cleared resets its flip-flops.
// [RULE9] Square buffer on only when bit 7 set and sine select clear.
// [RULE10] Sine buffer on only when bit 8 set and sine select set.
// [RULE11] Bits 3 to 6 gate four reference clocks to the digital core.
// [RULE12] Driver force set: driver follows bit 0; else on only during reads.
// [RULE13] Fourteen-bit ratio divides crystal; host never writes zero.
// [RULE14] Register 03h bit 14 set uses the divider, cleared bypasses it.
// [RULE15] Auto select bypasses the divider at ratio one, uses it otherwise.
// [RULE16] Register 03h bit 16 selects sine reference, else square.
// [RULE17] Duty mode bit lengthens prescaler low time from 15 to 47.
// [RULE18] Polarity bit inverts the phase detector sense.
// [RULE19] Register 05h bits 1 and 2 cleared mask up and down pulses.
// [RULE20] Delay field resets to 2; host should program 001.
// [RULE21] Up code bits 4:0, down code bits 9:5, 125uA per step.
// [RULE22] Register 01h bit 10 prescaler bias, bit 0 VCO buffer, reset 1.
// [RULE23] Frame opens with direction bit, low for write, then six address bits.
// [RULE24] Then 24 data bits, most significant first, one per serial clock.
// [RULE25] Undefined register bits read zero and ignore writes.
// [RULE26] A write lands only after the full 32-clock frame.
`ifndef SYNREG_MAP_VH
`define SYNREG_MAP_VH
`define SYNREG_ADDR_ENABLE   6'h01
`define SYNREG_ADDR_SDOFORCE 6'h02
`define SYNREG_ADDR_REFPATH  6'h03
`define SYNREG_ADDR_DUTY     6'h04
`define SYNREG_ADDR_PFD      6'h05
`define SYNREG_ADDR_PFDDLY   6'h06
`define SYNREG_ADDR_PUMP     6'h07
`define SYNREG_RST_ENABLE    16'hFE9B
`define SYNREG_RST_SDOFORCE  2'h3
`define SYNREG_RST_REFPATH   17'h0_8001
`define SYNREG_RST_DUTY      1'h0
`define SYNREG_RST_PFD       3'h6
`define SYNREG_RST_PFDDLY    3'h2
`define SYNREG_RST_PUMP      10'h210
`define SYNREG_MASK_ENABLE   24'h00_FFFF
`define SYNREG_MASK_SDOFORCE 24'h00_0003
`define SYNREG_MASK_REFPATH  24'h01_FFFF
`define SYNREG_MASK_DUTY     24'h00_0001
`define SYNREG_MASK_PFD      24'h00_0007
`define SYNREG_MASK_PFDDLY   24'h00_0007
`define SYNREG_MASK_PUMP     24'h00_03FF
`define SYNREG_EN_VCOBUF     0
`define SYNREG_EN_BIAS       1
`define SYNREG_EN_REFDIV     2
`define SYNREG_EN_MUXCLK     3
`define SYNREG_EN_DIVCLK     4
`define SYNREG_EN_SQCLK      5
`define SYNREG_EN_SINCLK     6
`define SYNREG_EN_SQBUF      7
`define SYNREG_EN_SINBUF     8
`define SYNREG_EN_VCOCLK     9
`define SYNREG_EN_PRESC      10
`define SYNREG_EN_LKDDIG     11
`define SYNREG_EN_PUMP       12
`define SYNREG_EN_DSMRUN     13
`define SYNREG_EN_LKDRUN     14
`define SYNREG_EN_SLIP       15
`define SYNREG_RP_DIVSEL     14
`define SYNREG_RP_AUTO       15
`define SYNREG_RP_SINSEL     16
`define SYNREG_FRAME_BITS    6'd32
`define SYNREG_ADDR_LAST     6'd7
`endif

// ### logic/synreg_shifter.v
// Purpose: Serial frame engine: direction, address, 24 data bits
// Assumes: Serial clock, enable and data already synchronised to clk_sys_i
// Notes:   Read data is shifted out on serial clock rises, MSB first
`timescale 1ns/10ps
`default_nettype none
`include "synreg_map.vh"
module synreg_shifter (
   input  wire        clk_sys_i,
   input  wire        reset_n_i,
   input  wire        sen_i,
   input  wire        sck_rise_i,
   input  wire        sck_fall_i,
   input  wire        sdi_i,
   input  wire [23:0] rd_data_i,
   output reg  [5:0]  addr_o,
   output reg  [23:0] wr_data_o,
   output reg         wr_pulse_o,
   output reg         rd_active_o,
   output reg         sdo_o
);
   reg [5:0]  bit_cnt_reg;
   reg        is_read_reg;
   reg [23:0] rd_shift_reg;
   // ===========================================================
   // Frame sequencing
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_cnt_reg  <= 6'd0;
         is_read_reg  <= 1'b0;
         rd_shift_reg <= 24'h00_0000;
         addr_o       <= 6'd0;
         wr_data_o    <= 24'h00_0000;
         wr_pulse_o   <= 1'b0;
         rd_active_o  <= 1'b0;
         sdo_o        <= 1'b0;
      end else begin
         wr_pulse_o <= 1'b0;
         if (!sen_i) begin
            bit_cnt_reg <= 6'd0;
            rd_active_o <= 1'b0;
         end else if (sck_rise_i && bit_cnt_reg < `SYNREG_FRAME_BITS) begin
            bit_cnt_reg <= bit_cnt_reg + 6'd1;
            if (bit_cnt_reg == 6'd0) begin
               is_read_reg <= sdi_i; // RULE23
               rd_active_o <= sdi_i;
            end else if (bit_cnt_reg <= 6'd6) begin
               addr_o <= {addr_o[4:0], sdi_i}; // RULE23
               if (bit_cnt_reg == 6'd6)
                  rd_shift_reg <= 24'h00_0000;
            end else begin
               if (bit_cnt_reg != `SYNREG_FRAME_BITS - 6'd1)
                  wr_data_o <= {wr_data_o[22:0], sdi_i}; // RULE24
               if (is_read_reg) begin
                  if (bit_cnt_reg == 6'd7) begin
                     sdo_o        <= rd_data_i[23]; // RULE24
                     rd_shift_reg <= {rd_data_i[22:0], 1'b0};
                  end else begin
                     sdo_o        <= rd_shift_reg[23];
                     rd_shift_reg <= {rd_shift_reg[22:0], 1'b0};
                  end
               end
               if (bit_cnt_reg == `SYNREG_FRAME_BITS - 6'd1 && !is_read_reg)
                  wr_pulse_o <= 1'b1; // RULE26
            end
         end else if (sck_fall_i && bit_cnt_reg == `SYNREG_FRAME_BITS) begin
            rd_active_o <= 1'b0;
         end
      end
   end
endmodule // synreg_shifter
`default_nettype wire

// ### logic/synreg_bank.v
// Purpose: Control register bank 01h..07h of the synthesizer behind a four-wire port
// Assumes: Serial pins are asynchronous to clk_sys_i; serial clock well below 1/6 of it
// Notes:   All control outputs come from flip-flops
`timescale 1ns/10ps
`default_nettype none
`include "synreg_map.vh"
module synreg_bank (
   input  wire        clk_sys_i,
   input  wire        reset_n_i,
   input  wire        sen_i,
   input  wire        sck_i,
   input  wire        sdi_i,
   input  wire        lock_status_i,
   output reg         lock_or_serial_out_pin_o,
   output reg         lock_or_serial_out_pin_oe_n_o,
   output reg         vco_buffer_on_o,
   output reg         loop_bias_on_o,
   output reg         ref_div_run_o,
   output reg         mux_clk_to_core_o,
   output reg         div_clk_to_core_o,
   output reg         sq_clk_to_core_o,
   output reg         sin_clk_to_core_o,
   output reg         square_input_buffer_on_o,
   output reg         sine_input_buffer_on_o,
   output reg         dsm_clk_from_vco_o,
   output reg         presc_bias_on_o,
   output reg         lock_logic_run_o,
   output reg         pump_output_on_o,
   output reg         dsm_run_o,
   output reg         lock_det_run_o,
   output reg         slip_guard_on_o,
   output reg [13:0]  ref_div_ratio_o,
   output reg         ref_div_used_o,
   output reg         sine_ref_sel_o,
   output reg         presc_long_low_o,
   output reg         pfd_invert_o,
   output reg         pfd_up_pass_o,
   output reg         pfd_dn_pass_o,
   output reg [2:0]   pfd_delay_o,
   output reg [4:0]   pump_up_current_code_o,
   output reg [4:0]   pump_down_current_code_o
);
   // ===========================================================
   // Pin synchronisers: three stages, change once stages 2 and 3 agree
   reg [2:0] sen_sync_reg;
   reg [2:0] sck_sync_reg;
   reg [2:0] sdi_sync_reg;
   reg       sen_reg;
   reg       sck_reg;
   reg       sdi_reg;
   reg       sck_prev_reg;
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sen_sync_reg <= 3'h0;
         sck_sync_reg <= 3'h0;
         sdi_sync_reg <= 3'h0;
         sen_reg      <= 1'b0;
         sck_reg      <= 1'b0;
         sdi_reg      <= 1'b0;
         sck_prev_reg <= 1'b0;
      end else begin
         sen_sync_reg <= {sen_sync_reg[1:0], sen_i};
         sck_sync_reg <= {sck_sync_reg[1:0], sck_i};
         sdi_sync_reg <= {sdi_sync_reg[1:0], sdi_i};
         if (sen_sync_reg[1] == sen_sync_reg[2])
            sen_reg <= sen_sync_reg[2];
         if (sck_sync_reg[1] == sck_sync_reg[2])
            sck_reg <= sck_sync_reg[2];
         if (sdi_sync_reg[1] == sdi_sync_reg[2])
            sdi_reg <= sdi_sync_reg[2];
         sck_prev_reg <= sck_reg;
      end
   end
   wire sck_rise = sck_reg & ~sck_prev_reg;
   wire sck_fall = ~sck_reg & sck_prev_reg;

   // ===========================================================
   // Serial frame engine
   wire [5:0]  fr_addr;
   wire [23:0] fr_data;
   wire        fr_wr;
   wire        fr_rd_active;
   wire        fr_sdo;
   reg  [23:0] rd_data;
   synreg_shifter u_shifter (
      .clk_sys_i   (clk_sys_i),
      .reset_n_i   (reset_n_i),
      .sen_i       (sen_reg),
      .sck_rise_i  (sck_rise),
      .sck_fall_i  (sck_fall),
      .sdi_i       (sdi_reg),
      .rd_data_i   (rd_data),
      .addr_o      (fr_addr),
      .wr_data_o   (fr_data),
      .wr_pulse_o  (fr_wr),
      .rd_active_o (fr_rd_active),
      .sdo_o       (fr_sdo)
   );

   // ===========================================================
   // Register storage
   reg [15:0] enable_and_reset_reg;
   reg [1:0]  serial_out_driver_force_reg;
   reg [16:0] reference_path_reg;
   reg        prescaler_duty_cycle_reg;
   reg [2:0]  phase_detector_control_reg;
   reg [2:0]  phase_detector_delay_reg;
   reg [9:0]  pump_current_control_reg;
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         enable_and_reset_reg        <= `SYNREG_RST_ENABLE; // RULE22
         serial_out_driver_force_reg <= `SYNREG_RST_SDOFORCE;
         reference_path_reg          <= `SYNREG_RST_REFPATH;
         prescaler_duty_cycle_reg    <= `SYNREG_RST_DUTY;
         phase_detector_control_reg  <= `SYNREG_RST_PFD; // RULE19
         phase_detector_delay_reg    <= `SYNREG_RST_PFDDLY; // RULE20
         pump_current_control_reg    <= `SYNREG_RST_PUMP;
      end else if (fr_wr) begin // RULE26
         case (fr_addr)
            `SYNREG_ADDR_ENABLE:   enable_and_reset_reg        <= fr_data[15:0]; // RULE25
            `SYNREG_ADDR_SDOFORCE: serial_out_driver_force_reg <= fr_data[1:0];
            `SYNREG_ADDR_REFPATH:  reference_path_reg          <= fr_data[16:0];
            `SYNREG_ADDR_DUTY:     prescaler_duty_cycle_reg    <= fr_data[0];
            `SYNREG_ADDR_PFD:      phase_detector_control_reg  <= fr_data[2:0];
            `SYNREG_ADDR_PFDDLY:   phase_detector_delay_reg    <= fr_data[2:0];
            `SYNREG_ADDR_PUMP:     pump_current_control_reg    <= fr_data[9:0];
            default: begin
            end
         endcase
      end
   end

   // ===========================================================
   // Read mux: undefined bits and addresses read zero
   always @* begin
      case (fr_addr)
         `SYNREG_ADDR_ENABLE:   rd_data = {8'h00, enable_and_reset_reg}; // RULE25
         `SYNREG_ADDR_SDOFORCE: rd_data = {22'h00_0000, serial_out_driver_force_reg};
         `SYNREG_ADDR_REFPATH:  rd_data = {7'h00, reference_path_reg};
         `SYNREG_ADDR_DUTY:     rd_data = {23'h00_0000, prescaler_duty_cycle_reg};
         `SYNREG_ADDR_PFD:      rd_data = {21'h00_0000, phase_detector_control_reg};
         `SYNREG_ADDR_PFDDLY:   rd_data = {21'h00_0000, phase_detector_delay_reg};
         `SYNREG_ADDR_PUMP:     rd_data = {14'h0000, pump_current_control_reg};
         default:               rd_data = 24'h00_0000;
      endcase
   end

   // ===========================================================
   // Decoded control outputs
   wire [15:0] en = enable_and_reset_reg;
   wire [13:0] ratio = reference_path_reg[13:0];
   wire        div_use = reference_path_reg[`SYNREG_RP_AUTO] ?
                         (ratio != 14'h0001) : // RULE15
                         reference_path_reg[`SYNREG_RP_DIVSEL]; // RULE14
   wire        sin_sel = reference_path_reg[`SYNREG_RP_SINSEL];
   wire        drv_on = serial_out_driver_force_reg[1] ?
                        serial_out_driver_force_reg[0] : fr_rd_active; // RULE12
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lock_or_serial_out_pin_o      <= 1'b0;
         lock_or_serial_out_pin_oe_n_o <= 1'b1;
         vco_buffer_on_o               <= 1'b0;
         loop_bias_on_o                <= 1'b0;
         ref_div_run_o                 <= 1'b0;
         mux_clk_to_core_o             <= 1'b0;
         div_clk_to_core_o             <= 1'b0;
         sq_clk_to_core_o              <= 1'b0;
         sin_clk_to_core_o             <= 1'b0;
         square_input_buffer_on_o      <= 1'b0;
         sine_input_buffer_on_o        <= 1'b0;
         dsm_clk_from_vco_o            <= 1'b0;
         presc_bias_on_o               <= 1'b0;
         lock_logic_run_o              <= 1'b0;
         pump_output_on_o              <= 1'b0;
         dsm_run_o                     <= 1'b0;
         lock_det_run_o                <= 1'b0;
         slip_guard_on_o               <= 1'b0;
         ref_div_ratio_o               <= 14'h0001;
         ref_div_used_o                <= 1'b0;
         sine_ref_sel_o                <= 1'b0;
         presc_long_low_o              <= 1'b0;
         pfd_invert_o                  <= 1'b0;
         pfd_up_pass_o                 <= 1'b0;
         pfd_dn_pass_o                 <= 1'b0;
         pfd_delay_o                   <= 3'h0;
         pump_up_current_code_o        <= 5'h00;
         pump_down_current_code_o      <= 5'h00;
      end else begin
         lock_or_serial_out_pin_o      <= fr_rd_active ? fr_sdo : lock_status_i;
         lock_or_serial_out_pin_oe_n_o <= ~drv_on; // RULE12
         vco_buffer_on_o               <= en[`SYNREG_EN_VCOBUF]; // RULE22
         loop_bias_on_o                <= en[`SYNREG_EN_BIAS]; // RULE1
         ref_div_run_o                 <= en[`SYNREG_EN_REFDIV]; // RULE2
         mux_clk_to_core_o             <= en[`SYNREG_EN_MUXCLK]; // RULE11
         div_clk_to_core_o             <= en[`SYNREG_EN_DIVCLK]; // RULE11
         sq_clk_to_core_o              <= en[`SYNREG_EN_SQCLK]; // RULE11
         sin_clk_to_core_o             <= en[`SYNREG_EN_SINCLK]; // RULE11
         square_input_buffer_on_o      <= en[`SYNREG_EN_SQBUF] & ~sin_sel; // RULE9
         sine_input_buffer_on_o        <= en[`SYNREG_EN_SINBUF] & sin_sel; // RULE10
         dsm_clk_from_vco_o            <= en[`SYNREG_EN_VCOCLK]; // RULE3
         presc_bias_on_o               <= en[`SYNREG_EN_PRESC]; // RULE22
         lock_logic_run_o              <= en[`SYNREG_EN_LKDDIG]; // RULE7
         pump_output_on_o              <= en[`SYNREG_EN_PUMP]; // RULE4
         dsm_run_o                     <= en[`SYNREG_EN_DSMRUN]; // RULE5
         lock_det_run_o                <= en[`SYNREG_EN_LKDRUN]; // RULE6
         slip_guard_on_o               <= en[`SYNREG_EN_SLIP]; // RULE8
         ref_div_ratio_o               <= ratio; // RULE13
         ref_div_used_o                <= div_use & en[`SYNREG_EN_REFDIV]; // RULE2
         sine_ref_sel_o                <= sin_sel; // RULE16
         presc_long_low_o              <= prescaler_duty_cycle_reg; // RULE17
         pfd_invert_o                  <= phase_detector_control_reg[0]; // RULE18
         pfd_up_pass_o                 <= phase_detector_control_reg[1]; // RULE19
         pfd_dn_pass_o                 <= phase_detector_control_reg[2]; // RULE19
         pfd_delay_o                   <= phase_detector_delay_reg; // RULE20
         pump_up_current_code_o        <= pump_current_control_reg[4:0]; // RULE21
         pump_down_current_code_o      <= pump_current_control_reg[9:5]; // RULE21
      end
   end
endmodule // synreg_bank
`default_nettype wire

// ### tb/synreg_host.sv
// Purpose: Host model on the four-wire serial port of the control bank
// Assumes: Half serial period of 8 system clocks, well above the sampling need
// Notes:   Serial clock rests low between frames; data changes on falls
`timescale 1ns/10ps
`default_nettype none
module synreg_host (
   input  wire logic clk_sys_i,
   input  wire logic pin_i,
   output var  logic sen_o,
   output var  logic sck_o,
   output var  logic sdi_o
);
   // ==========================================
   // Frame driver
   initial begin
      sen_o = 1'b0;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
   task automatic frame(input logic rd, input logic [5:0] addr, input logic [23:0] data,
                        input int rises, output logic [23:0] q);
      logic [30:0] word;
      word = {rd, addr, data};
      q = 24'h0;
      @(posedge clk_sys_i);
      sen_o <= 1'b1;
      for (int i = 1; i <= rises; i++) begin
         sdi_o <= (i <= 31) ? word[31 - i] : 1'b0;
         repeat (8) @(posedge clk_sys_i);
         sck_o <= 1'b1;
         repeat (8) @(posedge clk_sys_i);
         sck_o <= 1'b0;
         if (i >= 8 && i <= 31) q = {q[22:0], pin_i};
      end
      repeat (12) @(posedge clk_sys_i) begin
         sen_o <= 1'b0;
         sdi_o <= ~sdi_o;
      end
   endtask
endmodule // synreg_host
`default_nettype wire

// ### tb/synreg_bank_checker.sv
// Purpose: Port assertions for the control bank
// Assumes: Bound to synreg_bank
// Notes:   Idle means serial enable low for eight clocks
`timescale 1ns/10ps
`default_nettype none
module synreg_bank_checker (
   input wire logic        clk_sys_i,
   input wire logic        reset_n_i,
   input wire logic        sen_i,
   input wire logic        lock_status_i,
   input wire logic        lock_or_serial_out_pin_o,
   input wire logic        lock_or_serial_out_pin_oe_n_o,
   input wire logic        vco_buffer_on_o,
   input wire logic        ref_div_run_o,
   input wire logic        square_input_buffer_on_o,
   input wire logic        sine_input_buffer_on_o,
   input wire logic        presc_bias_on_o,
   input wire logic [13:0] ref_div_ratio_o,
   input wire logic        ref_div_used_o,
   input wire logic        sine_ref_sel_o,
   input wire logic [2:0]  pfd_delay_o,
   input wire logic [4:0]  pump_up_current_code_o,
   input wire logic [4:0]  pump_down_current_code_o
);
   // ==========================================
   // Idle counter
   logic [3:0] sen_low_cnt;
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) sen_low_cnt <= 4'h0;
      else if (sen_i) sen_low_cnt <= 4'h0;
      else if (sen_low_cnt != 4'hF) sen_low_cnt <= sen_low_cnt + 4'h1;
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   // ==========================================
   // Assertions
   a_square_buf_gate: assert property (square_input_buffer_on_o |-> !sine_ref_sel_o)
      else $error("square buffer on with sine selected");
   a_sine_buf_gate: assert property (sine_input_buffer_on_o |-> sine_ref_sel_o)
      else $error("sine buffer on with square selected");
   a_div_use_run: assert property (ref_div_used_o |-> ref_div_run_o)
      else $error("divider used while held");
   a_ratio_nonzero: assert property (ref_div_ratio_o != 14'h0)
      else $error("zero divide ratio");
   a_quiet_stable: assert property ((sen_low_cnt >= 4'h8) |-> $stable({ref_div_ratio_o,
      ref_div_used_o, pfd_delay_o, pump_up_current_code_o, pump_down_current_code_o,
      vco_buffer_on_o, presc_bias_on_o, ref_div_run_o, sine_ref_sel_o}))
      else $error("control changed outside a frame");
   a_idle_pin_lock: assert property ((sen_low_cnt >= 4'h8) |-> (lock_or_serial_out_pin_o == $past(lock_status_i)))
      else $error("pin not showing lock status");
   a_reset_fields: assert property ($rose(reset_n_i) |=> (pfd_delay_o == 3'h2)
      && (pump_up_current_code_o == 5'h10) && (pump_down_current_code_o == 5'h10)
      && vco_buffer_on_o && presc_bias_on_o)
      else $error("wrong field values after reset");
   a_reset_driver: assert property ($rose(reset_n_i) |-> ##1 (!lock_or_serial_out_pin_oe_n_o
      && ref_div_ratio_o == 14'h1) [*2])
      else $error("driver or ratio wrong after reset");
endmodule // synreg_bank_checker
bind synreg_bank synreg_bank_checker u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
   .sen_i(sen_i), .lock_status_i(lock_status_i),
   .lock_or_serial_out_pin_o(lock_or_serial_out_pin_o),
   .lock_or_serial_out_pin_oe_n_o(lock_or_serial_out_pin_oe_n_o),
   .vco_buffer_on_o(vco_buffer_on_o), .ref_div_run_o(ref_div_run_o),
   .square_input_buffer_on_o(square_input_buffer_on_o),
   .sine_input_buffer_on_o(sine_input_buffer_on_o), .presc_bias_on_o(presc_bias_on_o),
   .ref_div_ratio_o(ref_div_ratio_o), .ref_div_used_o(ref_div_used_o),
   .sine_ref_sel_o(sine_ref_sel_o), .pfd_delay_o(pfd_delay_o),
   .pump_up_current_code_o(pump_up_current_code_o),
   .pump_down_current_code_o(pump_down_current_code_o));
`default_nettype wire

// ### tb/synreg_bank_tb_top.sv
// Purpose: Self-checking bench for the serial control bank
// Assumes: Host model drives the serial pins
// Notes:   Register model is compared after every write and read
`timescale 1ns/10ps
`default_nettype none
`include "synreg_map.vh"
module synreg_bank_tb_top;
   logic        clk_sys_i, reset_n_i, lock_status_i, pin_last;
   logic [23:0] mreg [0:8];
   integer      seed = 32'hc188;
   int          num_errors = 0;
   int          checks = 0;
   wire         sen, sck, sdi, pin_o, oe_n, pin_w, used, sinsel, ll, inv, upp, dnp;
   wire  [15:0] en_q;
   wire  [13:0] ratio;
   wire  [2:0]  dly;
   wire  [4:0]  up_c, dn_c;
   assign pin_w = oe_n ? ~pin_last : pin_o;
   synreg_host host (.clk_sys_i(clk_sys_i), .pin_i(pin_w), .sen_o(sen), .sck_o(sck), .sdi_o(sdi));
   synreg_bank DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sen_i(sen), .sck_i(sck),
      .sdi_i(sdi), .lock_status_i(lock_status_i), .lock_or_serial_out_pin_o(pin_o),
      .lock_or_serial_out_pin_oe_n_o(oe_n), .vco_buffer_on_o(en_q[0]), .loop_bias_on_o(en_q[1]),
      .ref_div_run_o(en_q[2]), .mux_clk_to_core_o(en_q[3]), .div_clk_to_core_o(en_q[4]),
      .sq_clk_to_core_o(en_q[5]), .sin_clk_to_core_o(en_q[6]),
      .square_input_buffer_on_o(en_q[7]), .sine_input_buffer_on_o(en_q[8]),
      .dsm_clk_from_vco_o(en_q[9]), .presc_bias_on_o(en_q[10]), .lock_logic_run_o(en_q[11]),
      .pump_output_on_o(en_q[12]), .dsm_run_o(en_q[13]), .lock_det_run_o(en_q[14]),
      .slip_guard_on_o(en_q[15]), .ref_div_ratio_o(ratio), .ref_div_used_o(used),
      .sine_ref_sel_o(sinsel), .presc_long_low_o(ll), .pfd_invert_o(inv), .pfd_up_pass_o(upp),
      .pfd_dn_pass_o(dnp), .pfd_delay_o(dly), .pump_up_current_code_o(up_c),
      .pump_down_current_code_o(dn_c));
   // ==========================================
   // Clock, lock status and released pin
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) lock_status_i <= 1'($random(seed));
   always @(posedge clk_sys_i) if (oe_n === 1'b0) pin_last <= pin_o;
   // ==========================================
   // Checking tasks
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic [23:0] mask(input int a);
      case (a)
         1: mask = `SYNREG_MASK_ENABLE;
         2: mask = `SYNREG_MASK_SDOFORCE;
         3: mask = `SYNREG_MASK_REFPATH;
         4: mask = `SYNREG_MASK_DUTY;
         5: mask = `SYNREG_MASK_PFD;
         6: mask = `SYNREG_MASK_PFDDLY;
         7: mask = `SYNREG_MASK_PUMP;
         default: mask = 24'h00_0000;
      endcase
   endfunction
   task automatic check_outs();
      logic [23:0] e;
      e = mreg[1];
      e[7] = e[7] & ~mreg[3][16];
      e[8] = e[8] & mreg[3][16];
      check({8'h0, en_q}, {8'h0, e[15:0]});
      check({8'h0, ratio, used, sinsel}, {8'h0, mreg[3][13:0], mreg[1][2] & (mreg[3][15] ?
         mreg[3][13:0] != 14'h1 : mreg[3][14]), mreg[3][16]});
      check({17'h0, ll, inv, upp, dnp, dly}, {17'h0, mreg[4][0], mreg[5][0], mreg[5][1],
         mreg[5][2], mreg[6][2:0]});
      check({14'h0, dn_c, up_c}, {14'h0, mreg[7][9:0]});
      check({23'h0, oe_n}, {23'h0, mreg[2][1] ? ~mreg[2][0] : 1'b1});
   endtask
   task automatic wr(input int a, input logic [23:0] d, input int rises);
      logic [23:0] q;
      host.frame(1'b0, 6'(a), d, rises, q);
      if (rises == 32 && a >= 1 && a <= 7) mreg[a] = d & mask(a);
      check_outs();
   endtask
   task automatic rd(input int a);
      logic [23:0] q;
      if (mreg[2][1:0] == 2'b10) return;
      host.frame(1'b1, 6'(a), 24'h0, 32, q);
      check(q, mreg[a]);
   endtask
   // ==========================================
   // Main sequence
   int          a;
   logic [23:0] d;
   logic [23:0] tbl [0:4] = '{24'h00_8001, 24'h00_C001, 24'h00_8005, 24'h00_4001, 24'h01_0005};
   initial begin
      reset_n_i = 1'b0;
      mreg = '{24'h0, 24'(`SYNREG_RST_ENABLE), 24'(`SYNREG_RST_SDOFORCE),
         24'(`SYNREG_RST_REFPATH), 24'(`SYNREG_RST_DUTY), 24'(`SYNREG_RST_PFD),
         24'(`SYNREG_RST_PFDDLY), 24'(`SYNREG_RST_PUMP), 24'h0};
      repeat (4) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      check_outs();
      for (int i = 0; i <= 8; i++) rd(i);
      wr(6, 24'h00_0001, 32);
      for (int n = 0; n < 30; n++) begin
         a = int'($unsigned($random(seed)) % 9);
         d = 24'($random(seed));
         if (a == 3 && d[13:0] == 14'h0) d[0] = 1'b1;
         wr(a, d, 32);
         rd(a);
      end
      wr(2, 24'h00_0000, 32);
      rd(7);
      wr(2, 24'h00_0002, 32);
      wr(2, 24'h00_0001, 32);
      rd(5);
      wr(2, 24'h00_0003, 32);
      wr(1, mreg[1] | 24'h00_0004, 32);
      foreach (tbl[i]) wr(3, tbl[i], 32);
      wr(6, 24'h00_0005, 31);
      rd(6);
      summarize();
   end
   initial begin
      repeat (80000) @(posedge clk_sys_i);
      num_errors++;
      summarize();
   end
endmodule // synreg_bank_tb_top
`default_nettype wire
